// >>> src/scl_defs.svh
`ifndef SCL_DEFS_SVH
`define SCL_DEFS_SVH

// ----------------------------------------------------------------
// Framing
// ----------------------------------------------------------------
`define SCL_TX_LAST 4'h8
`define SCL_RX_LAST 3'h7
`define SCL_LINE_IDLE 1'b1

// ----------------------------------------------------------------
// Clock modes
// ----------------------------------------------------------------
`define SCL_CLK_MODE_ZERO 3'h0
`define SCL_CLK_MODE_STROBE 3'h1
`define SCL_CLK_MODE_XTAL_A 3'h4
`define SCL_CLK_MODE_SYNC 3'h5
`define SCL_CLK_MODE_XTAL_B 3'h6
`define SCL_CLK_MODE_XTAL_C 3'h7

// ----------------------------------------------------------------
// Crossing widths
// ----------------------------------------------------------------
`define SCL_LINK_SYNC_W 17
`define SCL_SYS_SYNC_W 5

`endif

// >>> src/scl_pkg.sv
`default_nettype none

package scl_pkg;
  typedef enum logic [1:0] {
    rts_on_tx = 2'h0,
    rts_on_rx = 2'h1,
    rts_off = 2'h2
  } scl_rts_opt_type;

  typedef enum logic [2:0] {
    tx_idle = 3'h1,
    tx_wait = 3'h2,
    tx_shift = 3'h4
  } scl_tx_state_type;

  typedef logic [2:0] scl_clk_mode_type;
endpackage

`default_nettype wire

// >>> src/scl_sync.sv
`timescale 1ns/1ps
`default_nettype none

module scl_sync #(
  parameter int WIDTH = 1
) (
  // Clock
  input wire logic i_clk,
  // Signals
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_level,
  output logic [WIDTH-1:0] o_edge
);
  import scl_pkg::*;

  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] last;

  // Only the second stage looks at the first one
  always_ff @(posedge i_clk) begin
    meta <= i_async;
    o_level <= meta;
    last <= o_level;
  end

  assign o_edge = o_level ^ last;
endmodule

`default_nettype wire

// >>> src/scl_link_serializer.sv
`timescale 1ns/1ps
`default_nettype none
`include "scl_defs.svh"

module scl_link_serializer (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Control
  input wire logic i_load,
  input wire logic [7:0] i_data,
  input wire logic i_enable,
  input wire logic i_wait_sync,
  input wire logic i_frame_sync,
  input wire logic i_nrzi,
  input wire logic i_collision,
  // Line side
  output logic o_bit,
  output logic o_active,
  output logic o_done
);
  import scl_pkg::*;

  scl_tx_state_type state;
  logic [8:0] shift;
  logic [3:0] count;
  logic last_bit;

  assign last_bit = (count == `SCL_TX_LAST) && i_enable;
  assign o_active = (state == tx_shift);

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state <= tx_idle;
    end else begin
      case (state)
        tx_idle: if (i_load) state <= i_wait_sync ? tx_wait : tx_shift;
        tx_wait: if (i_frame_sync) state <= tx_shift;
        tx_shift: if (i_collision || last_bit) state <= tx_idle;
        default: state <= tx_idle;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_done <= 1'b0;
    end else begin
      o_done <= o_active && (i_collision || last_bit);
    end
  end

  // Shifting freezes while the transmitter is not enabled
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      shift <= 9'h1ff;
      count <= 4'h0;
    end else if (state == tx_idle && i_load) begin
      shift <= {i_data, 1'b0};
      count <= 4'h0;
    end else if (o_active && i_enable) begin
      shift <= {1'b1, shift[8:1]};
      count <= count + 4'h1;
    end
  end

  // NRZI: a zero toggles the line, a one holds it, so idle ones keep it
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_bit <= `SCL_LINE_IDLE;
    end else if (o_active && i_enable) begin
      o_bit <= i_nrzi ? (shift[0] ? o_bit : ~o_bit) : shift[0];
    end else if (!o_active && !i_nrzi) begin
      o_bit <= `SCL_LINE_IDLE;
    end
  end

  tx_gate_a: assert property (@(posedge i_clk) disable iff (i_rst)
    o_active && !i_enable && !i_collision |=> $stable(count) && $stable(o_bit))
    else $error("serializer advanced while transmitter disabled");

  col_abort_a: assert property (@(posedge i_clk) disable iff (i_rst)
    o_active && i_collision |=> !o_active && o_done)
    else $error("collision did not abort the frame");
endmodule

`default_nettype wire

// >>> src/scl_channel.sv
`timescale 1ns/1ps
`default_nettype none
`include "scl_defs.svh"

module scl_channel (
  // Clocks and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_transmit_clock_pin,
  // Configuration
  input wire logic i_rts_control,
  input wire logic i_bus_config,
  input wire scl_pkg::scl_rts_opt_type i_rts_option,
  input wire logic i_nrzi,
  input wire logic i_idle_fill,
  input wire logic i_open_drain,
  input wire logic i_pin_swap_select,
  input wire scl_pkg::scl_clk_mode_type i_clock_mode,
  input wire logic i_clock_mode_b,
  input wire logic i_master_clock,
  input wire logic i_auto_start,
  input wire logic i_cts_irq_enable,
  input wire logic i_cd_irq_enable,
  // Transmit data
  input wire logic i_tx_valid,
  input wire logic [7:0] i_tx_data,
  output logic o_tx_ready,
  // Receive data
  output logic o_rx_valid,
  output logic [7:0] o_rx_data,
  // Status and events
  output logic o_cts_change_irq,
  output logic o_cd_change_irq,
  output logic o_collision,
  output logic o_carrier_detect,
  output logic o_tx_enabled,
  output logic o_common_clock_sel,
  // Line pins
  output logic o_request_send_n,
  input wire logic i_cts_n_collision_data_in,
  input wire logic i_carrier_detect_in_n,
  input wire logic i_txd_pin,
  output logic o_txd_pin,
  output logic o_txd_oe_n,
  input wire logic i_rxd_pin,
  output logic o_rxd_pin,
  output logic o_rxd_oe_n
);
  import scl_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic link_rst_meta;
  logic link_rst;
  logic [`SCL_LINK_SYNC_W-1:0] lk_in;
  logic [`SCL_LINK_SYNC_W-1:0] lk_lvl;
  logic [`SCL_LINK_SYNC_W-1:0] lk_edge;
  logic [`SCL_SYS_SYNC_W-1:0] sy_in;
  logic [`SCL_SYS_SYNC_W-1:0] sy_lvl;
  logic [`SCL_SYS_SYNC_W-1:0] sy_edge;
  logic rts_ctl_s, bus_s, nrzi_s, idle_s, od_s, swap_s, auto_s;
  scl_rts_opt_type opt_s;
  scl_clk_mode_type mode_s;
  logic req_s, req_edge, cts_s, cd_s, cd_edge, txp_s, rxp_s;
  logic req_tgl, ack_tgl, rx_tgl, col_tgl;
  logic [7:0] tx_word;
  logic [7:0] rx_word;
  logic ser_bit, ser_active, ser_done;
  logic tx_en, frame_sync, collision, pending, busy;
  logic [2:0] col_hist;
  logic tx_act_d1, rts_hold;
  logic next_rts_n, txd_val, drv_val, drv_oe_n;
  logic rx_in, rx_en, rx_start, rx_active;
  logic [2:0] rx_count;
  logic [7:0] rx_shift;

  function automatic logic uses_common(input scl_clk_mode_type mode,
                                       input logic sub_b,
                                       input logic master);
    uses_common = (mode == `SCL_CLK_MODE_XTAL_A) || (mode == `SCL_CLK_MODE_XTAL_B) ||
                  (mode == `SCL_CLK_MODE_XTAL_C) ||
                  ((mode == `SCL_CLK_MODE_ZERO) && sub_b) || master;
  endfunction

  // ----------------------------------------------------------------
  // Link domain: reset and crossings in
  // ----------------------------------------------------------------
  // Reset is synchronous, so a plain two-stage copy serves the link side
  always_ff @(posedge i_transmit_clock_pin) begin
    link_rst_meta <= i_sys_rst;
    link_rst <= link_rst_meta;
  end

  // Configuration is quasi-static; change it only while the link is idle
  assign lk_in = {i_rts_control, i_bus_config, i_rts_option, i_nrzi, i_idle_fill,
                  i_open_drain, i_pin_swap_select, i_clock_mode, i_auto_start, req_tgl,
                  i_cts_n_collision_data_in, i_carrier_detect_in_n, i_txd_pin, i_rxd_pin};

  scl_sync #(.WIDTH(`SCL_LINK_SYNC_W)) u_link_sync (
    .i_clk(i_transmit_clock_pin),
    .i_async(lk_in),
    .o_level(lk_lvl),
    .o_edge(lk_edge)
  );

  assign rts_ctl_s = lk_lvl[16];
  assign bus_s = lk_lvl[15];
  assign opt_s = scl_rts_opt_type'(lk_lvl[14:13]);
  assign nrzi_s = lk_lvl[12];
  assign idle_s = lk_lvl[11];
  assign od_s = lk_lvl[10];
  assign swap_s = lk_lvl[9];
  assign mode_s = lk_lvl[8:6];
  assign auto_s = lk_lvl[5];
  assign req_s = lk_lvl[4];
  assign req_edge = lk_edge[4];
  assign cts_s = lk_lvl[3];
  assign cd_s = lk_lvl[2];
  assign cd_edge = lk_edge[2];
  assign txp_s = lk_lvl[1];
  assign rxp_s = lk_lvl[0];

  // ----------------------------------------------------------------
  // Link domain: transmitter
  // ----------------------------------------------------------------
  // In bus mode the shared pin carries bus data, so no clear-send gating
  assign tx_en = bus_s | !cts_s;
  assign frame_sync = cd_edge & !cd_s;

  scl_link_serializer u_ser (
    .i_clk(i_transmit_clock_pin),
    .i_rst(link_rst),
    .i_load(req_edge),
    .i_data(tx_word),
    .i_enable(tx_en),
    .i_wait_sync(mode_s == `SCL_CLK_MODE_SYNC),
    .i_frame_sync(frame_sync),
    .i_nrzi(nrzi_s),
    .i_collision(collision),
    .o_bit(ser_bit),
    .o_active(ser_active),
    .o_done(ser_done)
  );

  // Our released one reaches the synchronised pin three clocks later;
  // a zero seen there means another station is pulling the bus
  always_ff @(posedge i_transmit_clock_pin) begin
    if (link_rst) begin
      col_hist <= 3'h0;
    end else begin
      col_hist <= {col_hist[1:0], ser_active & ser_bit};
    end
  end

  assign collision = bus_s & ser_active & col_hist[2] & !cts_s;

  always_ff @(posedge i_transmit_clock_pin) begin
    if (link_rst) begin
      ack_tgl <= 1'b0;
      col_tgl <= 1'b0;
      tx_act_d1 <= 1'b0;
    end else begin
      ack_tgl <= ack_tgl ^ ser_done;
      col_tgl <= col_tgl ^ collision;
      tx_act_d1 <= ser_active;
    end
  end

  // ----------------------------------------------------------------
  // Link domain: request-send
  // ----------------------------------------------------------------
  assign pending = req_s ^ ack_tgl;
  assign busy = ser_active | pending;

  always_ff @(posedge i_transmit_clock_pin) begin
    if (link_rst) begin
      rts_hold <= 1'b0;
    end else begin
      rts_hold <= rts_ctl_s | (rts_hold & busy);
    end
  end

  always_comb begin
    if (!bus_s) begin
      next_rts_n = !(rts_ctl_s | (rts_hold & busy));
    end else begin
      case (opt_s)
        rts_on_tx: next_rts_n = !(tx_act_d1 & !collision);
        rts_on_rx: next_rts_n = !rx_active;
        default: next_rts_n = 1'b1;
      endcase
    end
  end

  always_ff @(posedge i_transmit_clock_pin) begin
    if (link_rst) begin
      o_request_send_n <= 1'b1;
    end else begin
      o_request_send_n <= next_rts_n;
    end
  end

  // ----------------------------------------------------------------
  // Link domain: data pins
  // ----------------------------------------------------------------
  always_comb begin
    txd_val = ser_bit;
    if (nrzi_s && idle_s && !rts_ctl_s) begin
      txd_val = ser_bit | o_request_send_n;
    end
    drv_val = od_s ? 1'b0 : txd_val;
    drv_oe_n = od_s ? txd_val : 1'b0;
  end

  always_ff @(posedge i_transmit_clock_pin) begin
    if (link_rst) begin
      o_txd_pin <= 1'b0;
      o_txd_oe_n <= 1'b1;
      o_rxd_pin <= 1'b0;
      o_rxd_oe_n <= 1'b1;
    end else begin
      o_txd_pin <= swap_s ? 1'b0 : drv_val;
      o_txd_oe_n <= swap_s ? 1'b1 : drv_oe_n;
      o_rxd_pin <= swap_s ? drv_val : 1'b0;
      o_rxd_oe_n <= swap_s ? drv_oe_n : 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Link domain: receiver
  // ----------------------------------------------------------------
  assign rx_in = swap_s ? txp_s : rxp_s;

  always_comb begin
    case (mode_s)
      `SCL_CLK_MODE_STROBE: rx_en = !cd_s;
      `SCL_CLK_MODE_SYNC: rx_en = 1'b1;
      default: rx_en = !auto_s | !cd_s;
    endcase
    rx_start = (mode_s == `SCL_CLK_MODE_SYNC) ? frame_sync : (rx_en & !rx_in);
  end

  // A word stays in rx_word for at least eight link clocks, far longer
  // than the toggle takes to cross, so no holding buffer is needed
  always_ff @(posedge i_transmit_clock_pin) begin
    if (link_rst) begin
      rx_active <= 1'b0;
      rx_count <= 3'h0;
      rx_shift <= 8'h00;
      rx_word <= 8'h00;
      rx_tgl <= 1'b0;
    end else if (!rx_active) begin
      if (rx_start) begin
        rx_active <= 1'b1;
        rx_count <= 3'h0;
      end
    end else if (rx_en) begin
      rx_shift <= {rx_in, rx_shift[7:1]};
      rx_count <= rx_count + 3'h1;
      if (rx_count == `SCL_RX_LAST) begin
        rx_active <= 1'b0;
        rx_word <= {rx_in, rx_shift[7:1]};
        rx_tgl <= ~rx_tgl;
      end
    end
  end

  // ----------------------------------------------------------------
  // System domain: crossings in
  // ----------------------------------------------------------------
  assign sy_in = {ack_tgl, rx_tgl, col_tgl, i_cts_n_collision_data_in,
                  i_carrier_detect_in_n};

  scl_sync #(.WIDTH(`SCL_SYS_SYNC_W)) u_sys_sync (
    .i_clk(i_clk),
    .i_async(sy_in),
    .o_level(sy_lvl),
    .o_edge(sy_edge)
  );

  // ----------------------------------------------------------------
  // System domain: transmit handshake
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_tx_ready <= 1'b1;
      req_tgl <= 1'b0;
      tx_word <= 8'h00;
    end else if (i_tx_valid && o_tx_ready) begin
      o_tx_ready <= 1'b0;
      req_tgl <= ~req_tgl;
      tx_word <= i_tx_data;
    end else if (sy_edge[4]) begin
      o_tx_ready <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // System domain: receive data and events
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_rx_valid <= 1'b0;
      o_rx_data <= 8'h00;
      o_collision <= 1'b0;
    end else begin
      o_rx_valid <= sy_edge[3];
      if (sy_edge[3]) begin
        o_rx_data <= rx_word;
      end
      o_collision <= sy_edge[2];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_cts_change_irq <= 1'b0;
      o_cd_change_irq <= 1'b0;
    end else begin
      o_cts_change_irq <= i_cts_irq_enable & !i_bus_config & sy_edge[1];
      o_cd_change_irq <= i_cd_irq_enable & sy_edge[0];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_carrier_detect <= 1'b0;
      o_tx_enabled <= 1'b0;
      o_common_clock_sel <= 1'b0;
    end else begin
      o_carrier_detect <= !sy_lvl[0];
      o_tx_enabled <= i_bus_config | !sy_lvl[1];
      o_common_clock_sel <= uses_common(i_clock_mode, i_clock_mode_b, i_master_clock);
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  rts_set_low_a: assert property (@(posedge i_transmit_clock_pin)
    disable iff (link_rst) !bus_s && rts_ctl_s |=> !o_request_send_n)
    else $error("request-send not low with control set");

  rts_hold_busy_a: assert property (@(posedge i_transmit_clock_pin)
    disable iff (link_rst) !bus_s && rts_hold && ser_active |=> !o_request_send_n)
    else $error("request-send rose during transmission");

  rts_tx_delay_a: assert property (@(posedge i_transmit_clock_pin)
    disable iff (link_rst) bus_s && opt_s == rts_on_tx && !ser_active
    ##1 bus_s && opt_s == rts_on_tx |=> o_request_send_n)
    else $error("request-send low without delayed transmission");

  rts_rx_low_a: assert property (@(posedge i_transmit_clock_pin)
    disable iff (link_rst) bus_s && opt_s == rts_on_rx && rx_active |=> !o_request_send_n)
    else $error("request-send high during reception");

  rts_off_high_a: assert property (@(posedge i_transmit_clock_pin)
    disable iff (link_rst) bus_s && opt_s == rts_off |=> o_request_send_n)
    else $error("disabled request-send went low");

  cts_irq_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    o_cts_change_irq |-> $past(sy_edge[1]) && $past(i_cts_irq_enable))
    else $error("clear-send event without a level change");

  cd_irq_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    i_cd_irq_enable && sy_edge[0] |=> o_cd_change_irq)
    else $error("carrier detect change lost");

  od_release_a: assert property (@(posedge i_transmit_clock_pin)
    disable iff (link_rst) od_s && !swap_s && txd_val |=> o_txd_oe_n && !o_txd_pin)
    else $error("open-drain pin driven high");

  or_fill_a: assert property (@(posedge i_transmit_clock_pin)
    disable iff (link_rst) nrzi_s && idle_s && !rts_ctl_s && !od_s && !swap_s
    && o_request_send_n |=> o_txd_pin)
    else $error("transmit pin not ORed with request-send");

  swap_pins_a: assert property (@(posedge i_transmit_clock_pin)
    disable iff (link_rst) swap_s |=> o_txd_oe_n && (o_rxd_oe_n == $past(drv_oe_n)))
    else $error("pin swap not applied");

  common_clk_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    i_clock_mode == `SCL_CLK_MODE_XTAL_A |=> o_common_clock_sel)
    else $error("common clock not selected");

  tx_handshake_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    i_tx_valid && o_tx_ready |=> !o_tx_ready)
    else $error("ready stayed high after a taken word");

  tx_done_c: cover property (@(posedge i_clk) disable iff (i_sys_rst)
    !o_tx_ready ##[1:200] o_tx_ready);
  rx_word_c: cover property (@(posedge i_clk) disable iff (i_sys_rst) o_rx_valid);
  collision_c: cover property (@(posedge i_clk) disable iff (i_sys_rst) o_collision);
endmodule

`default_nettype wire

// >>> tb/scl_far_end.sv
`timescale 1ns/1ps
`default_nettype none

module scl_far_end (
  // Link side
  input wire logic i_link_clk,
  input wire logic i_txd_pin,
  input wire logic i_txd_oe_n,
  // Bus control
  input wire logic i_jam,
  // Lines
  output logic o_rxd,
  output logic o_bus
);
  // ----------------------------------------------------------
  // Shared bus: pulled up when released, jam forces a collision
  // ----------------------------------------------------------
  assign o_bus = ~i_jam & (i_txd_oe_n | i_txd_pin);

  initial o_rxd = 1'h1;

  // Start bit, eight bits low bit first, then idle high
  task automatic send_byte(input logic [7:0] b);
    @(posedge i_link_clk);
    o_rxd <= 1'h0;
    for (int k = 0; k < 8; k++) begin
      @(posedge i_link_clk);
      o_rxd <= b[k];
    end
    @(posedge i_link_clk);
    o_rxd <= 1'h1;
  endtask
endmodule

`default_nettype wire

// >>> tb/serial_channel_line_control_tb.sv
`timescale 1ns/1ps
`default_nettype none

module serial_channel_line_control_tb;
  import scl_pkg::*;
  typedef struct packed {
    scl_clk_mode_type mode;
    logic sub_b, master, cts_n, cd_n, common, txen, carrier;
  } scl_tb_row_type;

  logic clk, link_clk, sys_rst, rts_control, bus_config, open_drain, swap;
  logic mode_b, master, cts_irq_en, cd_irq_en, tx_valid, cts_n, cd_n, jam;
  logic tx_ready, rx_valid, cts_irq, cd_irq, coll, carrier, tx_en, common;
  logic rts_n, txd, txd_oe_n, rxd_out, rxd_oe_n, far_rxd, bus;
  logic nrzi, idle_fill, auto_start;
  logic [7:0] tx_data, rx_data, got;
  scl_rts_opt_type rts_option;
  scl_clk_mode_type clock_mode;
  int err_total = 0, samples_checked = 0, cycles = 0;
  int n_coll = 0, n_cts = 0, n_cd = 0, n_rx = 0, c0, a0, b0;
  wire logic cts_pin = bus_config ? bus : cts_n;
  // Fields: mode, sub_b, master, cts_n, cd_n | common, tx enabled, carrier
  scl_tb_row_type rows [9] = '{10'h003, 10'h21c, 10'h30e, 10'h395, 10'h047,
    10'h12e, 10'h083, 10'h298, 10'h18a};

  always #2 clk = ~clk;
  always #62.5 link_clk = ~link_clk;

  scl_channel DUT (.i_clk(clk), .i_sys_rst(sys_rst), .i_transmit_clock_pin(link_clk),
    .i_rts_control(rts_control), .i_bus_config(bus_config), .i_rts_option(rts_option),
    .i_nrzi(nrzi), .i_idle_fill(idle_fill), .i_open_drain(open_drain),
    .i_pin_swap_select(swap), .i_clock_mode(clock_mode), .i_clock_mode_b(mode_b),
    .i_master_clock(master), .i_auto_start(auto_start), .i_cts_irq_enable(cts_irq_en),
    .i_cd_irq_enable(cd_irq_en), .i_tx_valid(tx_valid), .i_tx_data(tx_data),
    .o_tx_ready(tx_ready), .o_rx_valid(rx_valid), .o_rx_data(rx_data),
    .o_cts_change_irq(cts_irq), .o_cd_change_irq(cd_irq), .o_collision(coll),
    .o_carrier_detect(carrier), .o_tx_enabled(tx_en), .o_common_clock_sel(common),
    .o_request_send_n(rts_n), .i_cts_n_collision_data_in(cts_pin),
    .i_carrier_detect_in_n(cd_n), .i_txd_pin(bus), .o_txd_pin(txd),
    .o_txd_oe_n(txd_oe_n), .i_rxd_pin(far_rxd), .o_rxd_pin(rxd_out),
    .o_rxd_oe_n(rxd_oe_n));

  scl_far_end u_far (.i_link_clk(link_clk), .i_txd_pin(txd), .i_txd_oe_n(txd_oe_n),
    .i_jam(jam), .o_rxd(far_rxd), .o_bus(bus));

  // ----------------------------------------------------------
  // Event counters and hang guard
  // ----------------------------------------------------------
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (coll === 1'h1) n_coll <= n_coll + 1;
    if (cts_irq === 1'h1) n_cts <= n_cts + 1;
    if (cd_irq === 1'h1) n_cd <= n_cd + 1;
    if (rx_valid === 1'h1) n_rx <= n_rx + 1;
    if (cycles == 60000) begin
      err_total++;
      results();
    end
  end

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic done(input string t);
    $display("test %s finished, %0d mismatches so far", t, err_total);
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Config crosses by two flops, so give it a few link clocks
  task automatic settle(input int n);
    repeat (n) @(posedge link_clk);
    @(posedge clk);
  endtask

  task automatic wait_ready();
    int n;
    n = 0;
    while (tx_ready !== 1'h1 && n < 5000) begin
      @(posedge clk);
      n++;
    end
    chk("tx_ready", tx_ready, 8'h01);
  endtask

  task automatic send_word(input logic [7:0] d);
    tx_data <= d;
    tx_valid <= 1'h1;
    @(posedge clk);
    tx_valid <= 1'h0;
    @(posedge clk);
  endtask

  // Bits are sampled mid-cell, away from the link edge that moves them
  task automatic wait_start();
    int n;
    n = 0;
    do begin
      @(negedge link_clk);
      n++;
    end while (bus !== 1'h0 && n < 80);
  endtask

  task automatic get_frame(output logic [7:0] b);
    wait_start();
    for (int k = 0; k < 8; k++) begin
      @(negedge link_clk);
      b[k] = bus;
    end
    @(posedge clk);
  endtask

  // ----------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------
  initial begin
    {clk, link_clk, sys_rst} = 3'h1;
    {rts_control, bus_config, open_drain, swap, mode_b, master} = 6'h00;
    {cts_irq_en, cd_irq_en, tx_valid, jam, cts_n, cd_n} = 6'h03;
    clock_mode = 3'h0;
    {nrzi, idle_fill, auto_start} = 3'h0;
    rts_option = rts_on_tx;
    tx_data = 8'h00;
    repeat (5) @(posedge clk);
    settle(6);
    chk("ready_reset", tx_ready, 8'h01);
    chk("rts_reset", rts_n, 8'h01);
    chk("oe_reset", txd_oe_n, 8'h01);
    sys_rst <= 1'h0;
    settle(4);
    done("reset");
    foreach (rows[i]) begin
      clock_mode <= rows[i].mode;
      mode_b <= rows[i].sub_b;
      master <= rows[i].master;
      cts_n <= rows[i].cts_n;
      cd_n <= rows[i].cd_n;
      settle(4);
      chk("common_clock", common, rows[i].common);
      chk("tx_enabled", tx_en, rows[i].txen);
      chk("carrier", carrier, rows[i].carrier);
    end
    done("modes");
    clock_mode <= 3'h0;
    rts_control <= 1'h1;
    settle(4);
    chk("rts_set", rts_n, 8'h00);
    cts_n <= 1'h1;
    settle(4);
    send_word(8'ha5);
    rts_control <= 1'h0;
    settle(20);
    chk("line_held", bus, 8'h01);
    chk("rts_pending", rts_n, 8'h00);
    cts_n <= 1'h0;
    get_frame(got);
    chk("frame", got, 8'ha5);
    wait_ready();
    settle(4);
    chk("rts_release", rts_n, 8'h01);
    done("transmit");
    bus_config <= 1'h1;
    open_drain <= 1'h1;
    settle(4);
    chk("rts_bus_idle", rts_n, 8'h01);
    chk("od_idle", {txd, txd_oe_n}, 8'h01);
    send_word(8'h3c);
    wait_start();
    repeat (2) @(negedge link_clk);
    chk("rts_bus_tx", rts_n, 8'h00);
    wait_ready();
    settle(4);
    chk("rts_bus_after", rts_n, 8'h01);
    c0 = n_coll;
    send_word(8'hff);
    wait_start();
    repeat (2) @(negedge link_clk);
    @(posedge clk);
    jam <= 1'h1;
    settle(6);
    jam <= 1'h0;
    wait_ready();
    chk("collisions", 8'(n_coll - c0), 8'h01);
    done("bus_transmit");
    rts_option <= rts_on_rx;
    settle(4);
    c0 = n_rx;
    fork
      u_far.send_byte(8'h96);
      begin
        repeat (6) @(negedge link_clk);
        chk("rts_bus_rx", rts_n, 8'h00);
      end
    join
    settle(4);
    chk("rx_count", 8'(n_rx - c0), 8'h01);
    chk("rx_data", rx_data, 8'h96);
    rts_option <= rts_off;
    settle(4);
    send_word(8'h55);
    wait_start();
    repeat (3) @(negedge link_clk);
    chk("rts_off", rts_n, 8'h01);
    chk("od_value", txd, 8'h00);
    wait_ready();
    done("bus_options");
    bus_config <= 1'h0;
    open_drain <= 1'h0;
    swap <= 1'h1;
    settle(4);
    chk("swap_pins", {rxd_out, rxd_oe_n, txd_oe_n}, 8'h05);
    swap <= 1'h0;
    nrzi <= 1'h1;
    idle_fill <= 1'h1;
    settle(4);
    // Nine toggles leave the NRZI line low, so only the OR can show a one
    send_word(8'h00);
    wait_ready();
    settle(4);
    chk("or_fill", txd, 8'h01);
    idle_fill <= 1'h0;
    settle(4);
    chk("nrzi_level", txd, 8'h00);
    nrzi <= 1'h0;
    done("nrzi_fill");
    cts_irq_en <= 1'h1;
    cd_irq_en <= 1'h1;
    settle(4);
    a0 = n_cts;
    b0 = n_cd;
    cts_n <= 1'h1;
    settle(1);
    cts_n <= 1'h0;
    cd_n <= 1'h0;
    settle(2);
    chk("cts_events", 8'(n_cts - a0), 8'h02);
    chk("cd_events", 8'(n_cd - b0), 8'h01);
    cts_irq_en <= 1'h0;
    settle(4);
    cts_n <= 1'h1;
    settle(2);
    chk("cts_masked", 8'(n_cts - a0), 8'h02);
    done("events");
    // Carrier absent: auto-start in mode 0 and the strobe in mode 1 both block reception
    for (int m = 0; m < 2; m++) begin
      clock_mode <= 3'(m);
      auto_start <= 1'h1;
      cd_n <= 1'h1;
      settle(4);
      c0 = n_rx;
      u_far.send_byte(8'h96);
      settle(4);
      chk("rx_gated", 8'(n_rx - c0), 8'h00);
    end
    cd_n <= 1'h0;
    settle(4);
    c0 = n_rx;
    u_far.send_byte(8'h69);
    settle(4);
    chk("rx_strobe", rx_data, 8'h69);
    chk("rx_strobe_count", 8'(n_rx - c0), 8'h01);
    // Mode 5: the falling carrier pin frames a word of idle ones
    clock_mode <= 3'h5;
    cd_n <= 1'h1;
    settle(4);
    c0 = n_rx;
    cd_n <= 1'h0;
    settle(12);
    chk("rx_sync", 8'(n_rx - c0), 8'h01);
    chk("rx_sync_data", rx_data, 8'hff);
    done("receive_modes");
    results();
  end
endmodule

`default_nettype wire
